// File: shared/psm_params.svh
/*
  constants for the power saving sequencer: timer code layout, times and counts.
  assumes the includer runs at the 40 MHz system clock.
*/
`ifndef PSM_PARAMS_SVH
`define PSM_PARAMS_SVH
`define PSM_CLK_HZ 40000000
`define PSM_WAKE_HOLD_S 5
`define PSM_MIN_SLEEP_S 60
`define PSM_UNIT_MIN_S 32'd60
`define PSM_MODE_OFF 1'h0
`define PSM_UNIT_MSB 7
`define PSM_UNIT_LSB 5
`define PSM_VAL_MSB 4
`define PSM_VAL_LSB 0
`define PSM_POL_ACT_LOW 1'h0
`define PSM_POL_ACT_HIGH 1'h1
`endif

// File: shared/psm_pkg.sv
/*
  types for the power saving sequencer.
  assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package psm_pkg;
  typedef enum logic [4:0] {
    ST_OFF    = 5'h01,
    ST_BOOT   = 5'h02,
    ST_ACTIVE = 5'h04,
    ST_PSM    = 5'h08,
    ST_DOWN   = 5'h10
  } psm_state_t;
endpackage
`default_nettype wire

// File: rtl/psm_hold_qual.sv
/*
  hold qualifier: counts a synchronised request level on a tick enable.
  assumes req_i is already synchronised to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module psm_hold_qual #(
  parameter int unsigned HOLD_TICKS = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic req_i,
  output logic done_o
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (!req_i) begin
      cnt_nxt = '0;
    end else if (tick_i && cnt_r < HOLD_TICKS) begin
      cnt_nxt = cnt_r + 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign done_o = req_i && (cnt_r >= HOLD_TICKS);
endmodule
`default_nettype wire

// File: rtl/psm_wake_shutdown_control.sv
/*
  power saving mode sequencer: power-on, wake qualification, monitor output,
  forced shutdown gating, sim power and timer decoding.
  assumes a 40 MHz clock, pins raw from the board, configuration from firmware.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psm_params.svh"
// What this block does
// - low variant pin powers on and wakes
// - low pin held five seconds wakes
// - high resume pin wakes before update timer
// - high pin held five seconds wakes
// - monitor output low is sleep indication
// - shutdown input ignored while sleeping
// - shutdown acts only with monitor high
// - sim interface powered down in sleep
// - active timer expiry puts device in sleep
// - mode zero disables power saving
// - decode codes to one and two minutes
// - sleep only if gap exceeds sixty seconds
// - update timer expiry leaves sleep
// - both timers start together
module psm_wake_shutdown_control #(
  parameter logic WAKE_POLARITY = `PSM_POL_ACT_LOW,
  parameter int unsigned CLK_HZ = `PSM_CLK_HZ,
  parameter int unsigned BOOT_CYCLES = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic main_battery_supply_i,
  input wire logic wake_pin_i,
  input wire logic forced_poweroff_n_i,
  input wire logic psm_mode_i,
  input wire logic [7:0] active_time_code_i,
  input wire logic [7:0] update_time_code_i,
  input wire logic attach_done_i,
  output logic aux_supply_power_monitor_o,
  output logic sim_power_en_o,
  output logic psm_refused_o,
  output psm_pkg::psm_state_t state_o
);
  import psm_pkg::*;

  // 3gpp timer code to seconds; unit in top bits, count in low five
  function automatic logic [31:0] timer_secs(input logic [7:0] code, input logic is_t3412);
    logic [31:0] v;
    logic [2:0] u;
    v = {27'h0, code[`PSM_VAL_MSB:`PSM_VAL_LSB]};
    u = code[`PSM_UNIT_MSB:`PSM_UNIT_LSB];
    timer_secs = 32'h0;
    if (is_t3412) begin
      unique case (u)
        3'h0: timer_secs = v * 32'd600;
        3'h1: timer_secs = v * 32'd3600;
        3'h2: timer_secs = v * 32'd36000;
        // unit 3 counts minutes on this device, so code 01100010 is two minutes
        3'h3: timer_secs = v * `PSM_UNIT_MIN_S;
        3'h4: timer_secs = v * 32'd30;
        3'h5: timer_secs = v * 32'd60;
        3'h6: timer_secs = v * 32'd1152000;
        default: timer_secs = 32'h0;
      endcase
    end else begin
      unique case (u)
        3'h0: timer_secs = v * 32'd2;
        3'h1: timer_secs = v * 32'd60;
        3'h2: timer_secs = v * 32'd360;
        3'h3: timer_secs = v * `PSM_UNIT_MIN_S;
        default: timer_secs = 32'h0;
      endcase
    end
  endfunction

  localparam int unsigned SEC_CYCLES = CLK_HZ;

  // pins cross two flops before use
  logic [1:0] wake_sync_r;
  logic [1:0] shut_sync_r;
  logic [1:0] vbat_sync_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_sync_r <= {2{~WAKE_POLARITY}};
      shut_sync_r <= 2'h3;
      vbat_sync_r <= 2'h0;
    end else begin
      wake_sync_r <= {wake_sync_r[0], wake_pin_i};
      shut_sync_r <= {shut_sync_r[0], forced_poweroff_n_i};
      vbat_sync_r <= {vbat_sync_r[0], main_battery_supply_i};
    end
  end

  logic wake_req;
  logic shut_req;
  logic vbat_ok;
  assign wake_req = (WAKE_POLARITY == `PSM_POL_ACT_LOW) ? ~wake_sync_r[1]
                                                        : wake_sync_r[1];
  assign shut_req = ~shut_sync_r[1];
  assign vbat_ok = vbat_sync_r[1];

  // one-second tick for the slow timers
  logic [31:0] div_r;
  logic [31:0] div_nxt;
  logic tick;
  assign tick = (div_r == SEC_CYCLES - 1);
  always_comb begin
    div_nxt = tick ? 32'h0 : div_r + 32'h1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  logic wake_held;
  psm_hold_qual #(
    .HOLD_TICKS(`PSM_WAKE_HOLD_S)
  ) u_hold (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .req_i(wake_req),
    .done_o(wake_held)
  );

  logic [31:0] t_active;
  logic [31:0] t_update;
  logic gap_ok;
  assign t_active = timer_secs(active_time_code_i, 1'b0);
  assign t_update = timer_secs(update_time_code_i, 1'b1);
  assign gap_ok = (t_update > t_active) &&
                  (t_update - t_active > `PSM_MIN_SLEEP_S);

  psm_state_t state_r, state_nxt;
  logic [31:0] boot_r, boot_nxt;
  logic [31:0] act_r, act_nxt;
  logic [31:0] upd_r, upd_nxt;
  logic armed_r, armed_nxt;
  logic refused_r, refused_nxt;

  always_comb begin
    state_nxt = state_r;
    boot_nxt = boot_r;
    act_nxt = act_r;
    upd_nxt = upd_r;
    armed_nxt = armed_r;
    refused_nxt = refused_r;
    if (tick && upd_r != 32'h0) begin
      upd_nxt = upd_r - 32'h1;
    end
    unique case (state_r)
      ST_OFF: begin
        armed_nxt = 1'b0;
        if (vbat_ok && wake_held) begin
          state_nxt = ST_BOOT;
          boot_nxt = '0;
        end
      end
      ST_BOOT: begin
        boot_nxt = boot_r + 32'h1;
        if (boot_r == BOOT_CYCLES - 1) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (shut_req) begin
          state_nxt = ST_DOWN;
        end else if (attach_done_i) begin
          if (psm_mode_i == `PSM_MODE_OFF || !gap_ok) begin
            armed_nxt = 1'b0;
            refused_nxt = (psm_mode_i != `PSM_MODE_OFF);
          end else begin
            armed_nxt = 1'b1;
            refused_nxt = 1'b0;
            act_nxt = t_active;
            upd_nxt = t_update;
          end
        end else if (armed_r && tick) begin
          if (act_r <= 32'h1) begin
            state_nxt = ST_PSM;
            armed_nxt = 1'b0;
          end else begin
            act_nxt = act_r - 32'h1;
          end
        end
      end
      ST_PSM: begin
        // shutdown input not even looked at here
        if (wake_held) begin
          state_nxt = ST_BOOT;
          boot_nxt = '0;
        end else if (upd_r == 32'h0) begin
          state_nxt = ST_BOOT;
          boot_nxt = '0;
        end
      end
      ST_DOWN: begin
        // wait for release so a held line does not re-trigger
        if (!shut_req && !wake_held) begin
          state_nxt = ST_OFF;
        end
      end
      default: state_nxt = ST_OFF;
    endcase
    if (!vbat_ok) begin
      state_nxt = ST_OFF;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_OFF;
      boot_r <= '0;
      act_r <= '0;
      upd_r <= '0;
      armed_r <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      boot_r <= boot_nxt;
      act_r <= act_nxt;
      upd_r <= upd_nxt;
      armed_r <= armed_nxt;
      refused_r <= refused_nxt;
    end
  end

  logic mon_r;
  logic sim_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mon_r <= 1'b0;
      sim_r <= 1'b0;
    end else begin
      mon_r <= (state_nxt == ST_BOOT) || (state_nxt == ST_ACTIVE);
      sim_r <= (state_nxt == ST_ACTIVE);
    end
  end

  assign aux_supply_power_monitor_o = mon_r;
  assign sim_power_en_o = sim_r;
  assign psm_refused_o = refused_r;
  assign state_o = state_r;
endmodule
`default_nettype wire

// File: verif/psm_wake_shutdown_control_sva.sv
/* checker on the sequencer ports.
   assumes the wake variant is given by WAKE_POLARITY, as in the design. */
`timescale 1ns/1ps
`default_nettype none
`include "psm_params.svh"
module psm_sva #(
  parameter logic WAKE_POLARITY = `PSM_POL_ACT_LOW,
  parameter int unsigned CLK_HZ = `PSM_CLK_HZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wake_pin_i,
  input wire logic forced_poweroff_n_i,
  input wire logic psm_mode_i,
  input wire logic attach_done_i,
  input wire logic aux_supply_power_monitor_o,
  input wire logic sim_power_en_o,
  input wire logic psm_refused_o,
  input wire psm_pkg::psm_state_t state_o
);
  import psm_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // cycles the raw wake pin has been at its active level
  logic [31:0] held_r;
  logic [31:0] held_nxt;
  always_comb held_nxt = (wake_pin_i == WAKE_POLARITY) ? held_r + 32'h1 : 32'h0;
  always_ff @(posedge clk_i) held_r <= rst_i ? 32'h0 : held_nxt;
  property p_mon;
    aux_supply_power_monitor_o == (state_o inside {ST_BOOT, ST_ACTIVE});
  endproperty
  a_mon: assert property (p_mon) else $error("monitor wrong");
  property p_sim;
    sim_power_en_o == (state_o == ST_ACTIVE);
  endproperty
  a_sim: assert property (p_sim) else $error("sim powered");
  property p_sd;
    (state_o == ST_ACTIVE && !forced_poweroff_n_i) [*3] |=> state_o == ST_DOWN;
  endproperty
  a_sd: assert property (p_sd) else $error("no shutdown");
  property p_sd_gate;
    !(state_o inside {ST_ACTIVE, ST_DOWN}) |=> state_o != ST_DOWN;
  endproperty
  a_sd_gate: assert property (p_sd_gate) else $error("shutdown taken");
  property p_boot;
    $rose(state_o == ST_BOOT) |-> (state_o == ST_BOOT) [*8] ##[7:9] state_o == ST_ACTIVE;
  endproperty
  a_boot: assert property (p_boot) else $error("boot length");
  property p_wake;
    state_o == ST_OFF ##1 state_o == ST_BOOT |-> held_r >= 4 * CLK_HZ;
  endproperty
  a_wake: assert property (p_wake) else $error("short wake");
  property p_refuse;
    $rose(psm_refused_o) |-> $past(attach_done_i) && $past(psm_mode_i);
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad refuse");
  property p_mode_off;
    attach_done_i && !psm_mode_i && state_o == ST_ACTIVE |=> (state_o == ST_ACTIVE) [*8];
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("mode off left");
  property p_psm_in;
    $rose(state_o == ST_PSM) |-> $past(state_o) == ST_ACTIVE;
  endproperty
  a_psm_in: assert property (p_psm_in) else $error("bad sleep entry");
  c_psm: cover property ($rose(state_o == ST_PSM));
  c_down: cover property ($rose(state_o == ST_DOWN));
  c_ref: cover property ($rose(psm_refused_o));
endmodule
bind psm_wake_shutdown_control psm_sva #(.WAKE_POLARITY(WAKE_POLARITY), .CLK_HZ(CLK_HZ))
  u_psm_sva (.clk_i(clk_i),
  .rst_i(rst_i), .wake_pin_i(wake_pin_i), .forced_poweroff_n_i(forced_poweroff_n_i),
  .psm_mode_i(psm_mode_i), .attach_done_i(attach_done_i),
  .aux_supply_power_monitor_o(aux_supply_power_monitor_o),
  .sim_power_en_o(sim_power_en_o), .psm_refused_o(psm_refused_o), .state_o(state_o));
`default_nettype wire

// File: verif/psm_host_model.sv
/* host model on the wake and shutdown pins.
   assumes the device pulls the wake line up. */
`timescale 1ns/1ps
`default_nettype none
module psm_host_model (
  input wire logic wake_req_i,
  input wire logic sd_req_i,
  input wire logic bad_i,
  input wire logic mon_i,
  input wire logic resume_req_i,
  output logic wake_pin_o,
  output logic forced_poweroff_n_o,
  output logic resume_pin_o
);
  // push-pull resume line, held low unless a wake is wanted
  assign resume_pin_o = resume_req_i ? 1'h1 : 1'h0;
  // open drain: released reads high via the device pull-up
  assign wake_pin_o = wake_req_i ? 1'h0 : 1'h1;
  // bad_i lets a scenario break the monitor condition
  // monitor low is the only sleep sign, so the request is dropped then
  assign forced_poweroff_n_o = !(sd_req_i && (mon_i || bad_i));
endmodule
`default_nettype wire

// File: verif/psm_wake_shutdown_control_tb_top.sv
/* testbench: sequencer, host model and checker.
   assumes one second is ten clock cycles. */
`timescale 1ns/1ps
`default_nettype none
module psm_wake_shutdown_control_tb_top;
  import psm_pkg::*;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic sup = 1'h0, wreq = 1'h0, sreq = 1'h0, bad = 1'h0, mode = 1'h0, att = 1'h0;
  logic [7:0] act = 8'h00;
  logic [7:0] upd = 8'h00;
  logic wreq_h = 1'h0;
  logic wpin, fpo_n, mon, sim, refd;
  logic rpin, mon_h, sim_h;
  psm_state_t st;
  psm_state_t st_h;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  always #12.5 clk_i = ~clk_i;
  psm_host_model u_psm_host_model (.wake_req_i(wreq), .sd_req_i(sreq), .bad_i(bad),
    .mon_i(mon), .resume_req_i(wreq_h), .wake_pin_o(wpin), .forced_poweroff_n_o(fpo_n),
    .resume_pin_o(rpin));
  psm_wake_shutdown_control #(.CLK_HZ(10)) u_psm_wake_shutdown_control (.clk_i(clk_i),
    .rst_i(rst_i), .main_battery_supply_i(sup), .wake_pin_i(wpin),
    .forced_poweroff_n_i(fpo_n), .psm_mode_i(mode), .active_time_code_i(act),
    .update_time_code_i(upd), .attach_done_i(att), .aux_supply_power_monitor_o(mon),
    .sim_power_en_o(sim), .psm_refused_o(refd), .state_o(st));
  // second copy for the active-high resume variant
  psm_wake_shutdown_control #(.WAKE_POLARITY(1'h1), .CLK_HZ(10))
    u_psm_wake_shutdown_control_hi (.clk_i(clk_i),
    .rst_i(rst_i), .main_battery_supply_i(sup), .wake_pin_i(rpin),
    .forced_poweroff_n_i(fpo_n), .psm_mode_i(mode), .active_time_code_i(act),
    .update_time_code_i(upd), .attach_done_i(att), .aux_supply_power_monitor_o(mon_h),
    .sim_power_en_o(sim_h), .psm_refused_o(), .state_o(st_h));
  task automatic end_sim;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic chk(input logic [4:0] g, input logic [4:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wait_st(input psm_state_t e, input int n);
    for (int i = 0; i < n && st !== e; i++) @(negedge clk_i);
    chk(st, e);
  endtask
  task automatic wait_hi(input psm_state_t e, input int n);
    for (int i = 0; i < n && st_h !== e; i++) @(negedge clk_i);
    chk(st_h, e);
  endtask
  task automatic attach(input logic m, input logic [7:0] a, input logic [7:0] u);
    mode = m;
    act = a;
    upd = u;
    att = 1'h1;
    wt(1);
    att = 1'h0;
    wt(2);
  endtask
  task automatic t_power_on;
    chk(st, ST_OFF);
    sup = 1'h1;
    wreq = 1'h1;
    wt(30);
    wreq = 1'h0;
    wt(80);
    chk(st, ST_OFF);
    wreq = 1'h1;
    wt(40);
    chk(st, ST_OFF);
    wait_st(ST_BOOT, 40);
    chk(mon, 1'h1);
    wreq = 1'h0;
    wait_st(ST_ACTIVE, 30);
    chk(sim, 1'h1);
  endtask
  task automatic t_refuse;
    // one minute against three minutes: gap of two minutes is accepted
    attach(1'h1, 8'h61, 8'h63);
    chk(refd, 1'h0);
    attach(1'h1, 8'h61, 8'h62);
    chk(refd, 1'h1);
    attach(1'h0, 8'h0a, 8'h83);
    chk(refd, 1'h0);
    wt(300);
    chk(st, ST_ACTIVE);
  endtask
  task automatic t_sleep_wake;
    attach(1'h1, 8'h0a, 8'h83);
    wt(170);
    chk(st, ST_ACTIVE);
    wait_st(ST_PSM, 60);
    chk(sim, 1'h0);
    bad = 1'h1;
    sreq = 1'h1;
    wt(10);
    chk(st, ST_PSM);
    sreq = 1'h0;
    bad = 1'h0;
    wreq = 1'h1;
    wait_st(ST_BOOT, 90);
    wreq = 1'h0;
    wait_st(ST_ACTIVE, 30);
  endtask
  task automatic t_update;
    attach(1'h1, 8'h0a, 8'h83);
    wait_st(ST_PSM, 230);
    wt(650);
    chk(st, ST_PSM);
    wait_st(ST_BOOT, 100);
    wait_st(ST_ACTIVE, 30);
    chk(sim, 1'h1);
  endtask
  task automatic t_high_variant;
    wreq_h = 1'h1;
    wt(40);
    chk(st_h, ST_OFF);
    wait_hi(ST_BOOT, 30);
    chk(mon_h, 1'h1);
    wreq_h = 1'h0;
    wait_hi(ST_ACTIVE, 30);
    chk(sim_h, 1'h1);
    attach(1'h1, 8'h0a, 8'h83);
    wait_hi(ST_PSM, 200);
    chk(mon_h, 1'h0);
    chk(sim_h, 1'h0);
    wreq_h = 1'h1;
    wt(40);
    chk(st_h, ST_PSM);
    wait_hi(ST_BOOT, 30);
    wreq_h = 1'h0;
    wait_hi(ST_ACTIVE, 30);
  endtask
  task automatic t_shutdown;
    sreq = 1'h1;
    wt(4);
    chk(st, ST_DOWN);
    chk(mon, 1'h0);
    sreq = 1'h0;
    wait_st(ST_OFF, 10);
  endtask
  initial begin
    wt(5);
    rst_i = 1'h0;
    t_power_on();
    t_refuse();
    t_sleep_wake();
    t_update();
    t_shutdown();
    t_high_variant();
    end_sim();
  end
endmodule
`default_nettype wire
